// *** logic/smr_pkg.sv ***
`default_nettype none
package smr_pkg;
   localparam int NCH = 4;
   localparam int CLK_NS = 25;
   localparam int PWRUP_NS = 28650;
   // least wait rounds up to whole cycles
   localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [10:0] PWRUP_CNT = 11'(PWRUP_CYC);
   localparam logic [11:0] FAULT_CYC = 12'hFA0;
   //////////////////////////////////////////////////////////////////
   // byte offsets on the bus
   localparam logic [7:0] A_MCR = 8'h00;
   localparam logic [7:0] A_CCR = 8'h04;
   localparam logic [7:0] A_FIFO = 8'h14;
   localparam logic [7:0] A_STAT = 8'h24;
   localparam logic [7:0] A_FLUSH = 8'h28;
   // master_config_word fields
   localparam int M_POL = 0;
   localparam int M_BEH = 1;
   localparam int M_PROTB = 8;
   localparam int M_ODD = 12;
   // channel_config_word fields
   localparam int C_DEC = 0;
   localparam int C_SPD = 1;
   localparam int C_BLEN = 3;
   localparam int C_SUP = 5;
   localparam int C_TRIP = 6;
   localparam int C_HYS = 8;
   //////////////////////////////////////////////////////////////////
   // speed ranges in clock cycles, index is the speed field
   localparam logic [3:0][12:0] BT_MIN = {13'hC80, 13'h640, 13'h3E8, 13'h280};
   localparam logic [3:0][12:0] BT_MAX = {13'hF00, 13'h780, 13'h4B0, 13'h300};
   localparam logic [3:0][7:0] DG_LEN = {8'h20, 8'h10, 8'h0C, 8'h08};
   localparam logic [4:0] A_BITS = 5'h11;
   localparam logic [4:0] B_BASE = 5'h09;
   localparam logic [4:0] CRC_POLY = 5'h05;
   localparam logic [1:0] E_NONE = 2'h0;
   localparam logic [1:0] E_BIT = 2'h1;
   localparam logic [1:0] E_MANY = 2'h2;
   localparam logic [1:0] E_CHK = 2'h3;
   //////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {ST_PWR, ST_HUNT, ST_SYNC, ST_DATA, ST_IDLE} smr_st_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } smr_wb_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } smr_wb_rsp_t;
   typedef struct packed {
      logic [1:0] trip;
      logic hys;
   } smr_cmp_t;
   typedef struct packed {
      logic [15:0] channel_config_word;
      logic [1:0] sy;
      logic lvl;
      logic [7:0] dg;
      smr_st_t st;
      logic [12:0] cnt;
      logic [12:0] bt;
      logic early;
      logic [4:0] nb;
      logic [16:0] sh;
      logic [1:0][13:0] fe;
      logic [1:0] fc;
      logic lost;
      logic oc;
      logic [11:0] otmr;
   } smr_ch_t;
   typedef struct packed {
      logic [15:0] master_config_word;
      logic [10:0] pwr;
      smr_ch_t [3:0] ch;
      smr_wb_rsp_t wb;
      logic message_waiting_out;
      logic [3:0] sup;
      smr_cmp_t [3:0] cfgo;
   } smr_state_t;
   // all-zero reset: configuration words clear, decoders in ST_PWR
   localparam smr_state_t ST_RST = '0;
endpackage
`default_nettype wire

// *** logic/smr_top.sv ***
// What this block does
// - four channels, decoder enabled per channel config
// - zero rises mid-bit, one falls mid-bit
// - two zero sync bits set bit time
// - sync rate out of range: error, idle
// - centre edge within 75..125 percent, restarts count
// - one early edge ignored, second is error
// - no centre edge in window: bit error
// - idle 1.5 min bit; completes message
// - decode errors stored at once
// - decode error discards message, minimum bit time
// - one code per message, fixed priority
// - wait 28.65 us after reset before decoding
// - protocol A: sync, 12 data, 5 check
// - protocol A check x5+x2+1, mismatch flagged
// - protocol B: 8..11 data, parity checked
// - protocol B per channel, speed per channel
// - per channel FIFO, two entries deep
// - message waiting held while any FIFO occupied, except during bus cycles with select behaviour set
// - overwrite when full drops oldest, lost flag
// - read pops oldest, read or flush clears lost
// - trip point, hysteresis, speed dependent deglitch
// - fault timer latches channel off until re-enabled
// - odd or even parity for protocol B
// - message waiting polarity selectable
// - message waiting inactive when all FIFOs empty
//
// The register addresses and the Wishbone register port were decided locally.
`default_nettype none
module smr_top
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register bus
   input wire smr_pkg::smr_wb_req_t wb_i,
   output var smr_pkg::smr_wb_rsp_t wb_o,
   // sensor channels
   input wire logic [3:0] cmp_i,
   input wire logic [3:0] ilim_i,
   output var logic [3:0] sensor_supply_out_o,
   output var smr_pkg::smr_cmp_t [3:0] cmp_cfg_o,
   // host notification
   output var logic message_waiting_out_o
);
   import smr_pkg::*;

   smr_state_t q;
   smr_state_t n;
   smr_ch_t c;
   logic take;
   logic rd;
   logic wr;
   logic [15:0] wmask;
   logic [15:0] wval;
   logic [31:0] rdat;
   logic [1:0] spd;
   logic [12:0] bmin;
   logic [12:0] bmax;
   logic [12:0] idle;
   logic [4:0] nexp;
   logic isb;
   logic ok;
   logic flush;
   logic any_w;
   logic [1:0] err;
   logic [11:0] dat;
   logic [3:0] edg_w;
   logic [3:0] push_w;
   logic [3:0] pop_w;
   logic [3:0] cmpl_w;
   logic [3:0][12:0] lo_w;
   logic [3:0][12:0] hi_w;
   logic [3:0][13:0] pv_w;

   function automatic logic [4:0] crc5(input logic [11:0] d);
      logic [4:0] r;
      r = 5'h00;
      for (int k = 11; k >= 0; k--)
      begin
         if (r[4] ^ d[k])
            r = {r[3:0], 1'b0} ^ CRC_POLY;
         else
            r = {r[3:0], 1'b0};
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      n = q;
      c = q.ch[0];
      rdat = 32'h0000_0000;
      spd = 2'h0;
      bmin = 13'h0000;
      bmax = 13'h0000;
      idle = 13'h0000;
      nexp = 5'h00;
      isb = 1'b0;
      ok = 1'b0;
      flush = 1'b0;
      err = E_NONE;
      dat = 12'h000;
      edg_w = 4'h0;
      push_w = 4'h0;
      pop_w = 4'h0;
      cmpl_w = 4'h0;
      lo_w = '0;
      hi_w = '0;
      pv_w = '0;
      take = wb_i.cyc && wb_i.stb && !q.wb.ack;
      wr = take && wb_i.we;
      rd = take && !wb_i.we;
      wmask = {{8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
      wval = wb_i.dat[15:0];
      any_w = 1'b0;
      n.wb.ack = take;
      if (q.pwr != PWRUP_CNT)
         n.pwr = q.pwr + 11'h001;
      if (wr && wb_i.adr == A_MCR)
         n.master_config_word = (q.master_config_word & ~wmask) | (wval & wmask);
      if (wr && wb_i.adr == A_FLUSH && wb_i.sel[0])
         flush = 1'b1;
      for (int i = 0; i < NCH; i++)
      begin
         c = q.ch[i];
         any_w = any_w | (c.fc != 2'h0);
         if (wr && wb_i.adr == A_CCR + 8'(4 * i))
            n.ch[i].channel_config_word = (c.channel_config_word & ~wmask) | (wval & wmask);
         spd = c.channel_config_word[C_SPD +: 2];
         bmin = BT_MIN[spd];
         bmax = BT_MAX[spd];
         idle = bmin + (bmin >> 1);
         lo_w[i] = c.bt - (c.bt >> 2);
         hi_w[i] = c.bt + (c.bt >> 2);
         isb = q.master_config_word[M_PROTB + i];
         nexp = isb ? 5'(c.channel_config_word[C_BLEN +: 2]) + B_BASE : A_BITS;
         // the first stage feeds only the second one
         n.ch[i].sy = {c.sy[0], cmp_i[i]};
         // filter length follows the channel speed
         if (c.sy[1] == c.lvl)
            n.ch[i].dg = 8'h00;
         else if (c.dg + 8'h01 >= DG_LEN[spd])
         begin
            n.ch[i].dg = 8'h00;
            n.ch[i].lvl = c.sy[1];
            edg_w[i] = 1'b1;
         end
         else
            n.ch[i].dg = c.dg + 8'h01;
         if (c.cnt != 13'h1FFF)
            n.ch[i].cnt = c.cnt + 13'h0001;
         if (!c.channel_config_word[C_DEC] && c.st != ST_PWR)
            n.ch[i].st = ST_HUNT;
         else
         begin
            case (c.st)
               ST_PWR:
               begin
                  n.ch[i].bt = bmin;
                  if (q.pwr == PWRUP_CNT)
                     n.ch[i].st = ST_HUNT;
               end
               ST_HUNT:
               begin
                  // idle line is low, so the first sync centre rises
                  if (edg_w[i] && c.sy[1])
                  begin
                     n.ch[i].st = ST_SYNC;
                     n.ch[i].cnt = 13'h0000;
                  end
               end
               ST_SYNC:
               begin
                  // centre to centre of the two zeros is one bit time
                  if (edg_w[i] && c.sy[1])
                  begin
                     if (c.cnt >= bmin && c.cnt <= bmax)
                     begin
                        n.ch[i].st = ST_DATA;
                        n.ch[i].bt = c.cnt;
                        n.ch[i].cnt = 13'h0000;
                        n.ch[i].nb = 5'h00;
                        n.ch[i].early = 1'b0;
                        n.ch[i].sh = 17'h00000;
                     end
                     else
                        err = E_BIT;
                  end
                  else if (c.cnt > bmax + bmax)
                     err = E_BIT;
               end
               ST_DATA:
               begin
                  if (edg_w[i])
                  begin
                     if (c.cnt < lo_w[i])
                     begin
                        if (c.early)
                           err = E_BIT;
                        else
                           n.ch[i].early = 1'b1;
                     end
                     else if (c.cnt <= hi_w[i] && c.nb != nexp)
                     begin
                        // falling centre is a one, rising a zero
                        n.ch[i].sh = {c.sh[15:0], ~c.sy[1]};
                        n.ch[i].nb = c.nb + 5'h01;
                        n.ch[i].cnt = 13'h0000;
                        n.ch[i].early = 1'b0;
                     end
                     else if (c.nb == nexp)
                        err = E_MANY;
                     else
                        err = E_BIT;
                  end
                  else if (c.nb == nexp && c.cnt >= idle)
                  begin
                     cmpl_w[i] = 1'b1;
                     if (isb)
                     begin
                        dat = {1'b0, c.sh[11:1]};
                        ok = (^c.sh[11:0]) == q.master_config_word[M_ODD];
                     end
                     else
                     begin
                        dat = c.sh[16:5];
                        ok = crc5(c.sh[16:5]) == c.sh[4:0];
                     end
                     push_w[i] = 1'b1;
                     pv_w[i] = {ok ? E_NONE : E_CHK, dat};
                     n.ch[i].st = ST_HUNT;
                     n.ch[i].cnt = 13'h0000;
                  end
                  else if (c.nb != nexp && c.cnt > hi_w[i])
                     err = E_BIT;
               end
               ST_IDLE:
               begin
                  if (edg_w[i])
                     n.ch[i].cnt = 13'h0000;
                  else if (c.cnt >= idle)
                     n.ch[i].st = ST_HUNT;
               end
               default:
                  n.ch[i].st = ST_HUNT;
            endcase
         end
         // decode errors go straight into the FIFO, no idle wait
         if (err != E_NONE)
         begin
            push_w[i] = 1'b1;
            pv_w[i] = {err, 12'h000};
            n.ch[i].st = ST_IDLE;
            n.ch[i].bt = bmin;
            n.ch[i].cnt = 13'h0000;
            err = E_NONE;
         end
         // FIFO: pop, then flush, then push so a new event wins
         pop_w[i] = rd && wb_i.adr == A_FIFO + 8'(4 * i) && c.fc != 2'h0;
         if (pop_w[i])
         begin
            n.ch[i].fe[0] = c.fe[1];
            n.ch[i].fc = c.fc - 2'h1;
            n.ch[i].lost = 1'b0;
         end
         if (flush && wval[i])
         begin
            n.ch[i].fc = 2'h0;
            n.ch[i].lost = 1'b0;
         end
         if (push_w[i])
         begin
            if (n.ch[i].fc == 2'h2)
            begin
               n.ch[i].fe[0] = n.ch[i].fe[1];
               n.ch[i].fe[1] = pv_w[i];
               n.ch[i].lost = 1'b1;
            end
            else
            begin
               n.ch[i].fe[n.ch[i].fc[0]] = pv_w[i];
               n.ch[i].fc = n.ch[i].fc + 2'h1;
            end
         end
         // over-current: timer runs only while the supply is on
         if (ilim_i[i] && q.sup[i])
         begin
            if (c.otmr == FAULT_CYC)
               n.ch[i].oc = 1'b1;
            else
               n.ch[i].otmr = c.otmr + 12'h001;
         end
         else
            n.ch[i].otmr = 12'h000;
         // re-enable clears the latch only once the overload is gone
         if (wr && wb_i.adr == A_CCR + 8'(4 * i) && wb_i.sel[0] &&
             wval[C_SUP] && !ilim_i[i] && c.otmr != FAULT_CYC)
            n.ch[i].oc = 1'b0;
         n.sup[i] = n.ch[i].channel_config_word[C_SUP] && !n.ch[i].oc;
         n.cfgo[i].trip = n.ch[i].channel_config_word[C_TRIP +: 2];
         n.cfgo[i].hys = n.ch[i].channel_config_word[C_HYS];
         if (wb_i.adr == A_CCR + 8'(4 * i))
            rdat = {16'h0000, c.channel_config_word};
         else if (wb_i.adr == A_FIFO + 8'(4 * i))
            rdat = {15'h0000, c.lost, c.fc, (c.fc != 2'h0) ? c.fe[0] : 14'h0000};
      end
      if (wb_i.adr == A_MCR)
         rdat = {16'h0000, q.master_config_word};
      else if (wb_i.adr == A_STAT)
         rdat = {16'h0000, q.ch[3].fc, q.ch[2].fc, q.ch[1].fc, q.ch[0].fc,
                 q.ch[3].lost, q.ch[2].lost, q.ch[1].lost, q.ch[0].lost,
                 q.ch[3].oc, q.ch[2].oc, q.ch[1].oc, q.ch[0].oc};
      n.wb.dat = rd ? rdat : 32'h0000_0000;
      // select behaviour: bus activity stands in for the host select
      n.message_waiting_out = (any_w && !(q.master_config_word[M_BEH] && wb_i.cyc)) ^ q.master_config_word[M_POL];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         q <= ST_RST;
      else if (ce_i)
         q <= n;
   end

   assign wb_o = q.wb;
   assign sensor_supply_out_o = q.sup;
   assign cmp_cfg_o = q.cfgo;
   assign message_waiting_out_o = q.message_waiting_out;

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_early_twice;
      ce_i && q.ch[0].st == ST_DATA && edg_w[0] && q.ch[0].early &&
      q.ch[0].cnt < lo_w[0];
   endsequence
   sequence s_err_stored;
      q.ch[0].st == ST_IDLE && q.ch[0].bt == BT_MIN[q.ch[0].channel_config_word[C_SPD +: 2]];
   endsequence

   AST_BUS_ACK: assert property (ce_i && take |=> wb_o.ack ##1 (!$past(ce_i) || !wb_o.ack))
      else $error("bus ack not a single cycle after request");
   AST_EARLY_EDGE: assert property (s_early_twice |=> s_err_stored)
      else $error("second early edge did not abort decoding");
   AST_CENTRE: assert property (ce_i && q.ch[0].st == ST_DATA && edg_w[0] &&
      q.ch[0].cnt >= lo_w[0] && q.ch[0].cnt <= hi_w[0] && q.ch[0].nb < A_BITS &&
      q.ch[0].nb != 5'h00 |=> q.ch[0].cnt == 13'h0000 && q.ch[0].nb == $past(q.ch[0].nb) + 5'h01)
      else $error("valid centre not taken");
   AST_NO_CENTRE: assert property (ce_i && q.ch[0].st == ST_DATA && q.ch[0].channel_config_word[C_DEC] &&
      q.ch[0].nb == 5'h00 && q.ch[0].cnt > hi_w[0] && !edg_w[0] |-> push_w[0] &&
      pv_w[0][13:12] == E_BIT ##1 s_err_stored)
      else $error("missing centre not reported");
   AST_PWRUP: assert property (q.ch[0].st != ST_PWR |-> q.pwr == PWRUP_CNT)
      else $error("decoder left power-up wait early");
   AST_CRC_FAIL: assert property (cmpl_w[0] && !q.master_config_word[M_PROTB] &&
      crc5(q.ch[0].sh[16:5]) != q.ch[0].sh[4:0] |-> pv_w[0][13:12] == E_CHK)
      else $error("check mismatch not flagged");
   AST_DEPTH: assert property (q.ch[0].fc <= 2'h2)
      else $error("FIFO count above two");
   AST_LOST_SET: assert property (ce_i && push_w[0] && q.ch[0].fc == 2'h2 && !pop_w[0] |=>
      q.ch[0].lost && q.ch[0].fc == 2'h2 && q.ch[0].fe[1] == $past(pv_w[0]))
      else $error("overwrite of full FIFO not flagged");
   AST_LOST_CLR: assert property (ce_i && pop_w[0] && !push_w[0] |=>
      !q.ch[0].lost && q.ch[0].fc == $past(q.ch[0].fc) - 2'h1)
      else $error("read did not pop or clear lost");
   AST_MSG_ON: assert property (ce_i && any_w && !q.master_config_word[M_BEH] |=>
      message_waiting_out_o != $past(q.master_config_word[M_POL]))
      else $error("message waiting not asserted");
   AST_MSG_OFF: assert property (ce_i && !any_w |=>
      message_waiting_out_o == $past(q.master_config_word[M_POL]))
      else $error("message waiting active with empty FIFOs");
   AST_OC_LATCH: assert property (ce_i && ilim_i[1] && q.sup[1] && q.ch[1].otmr == FAULT_CYC
      |=> q.ch[1].oc ##1 !sensor_supply_out_o[1])
      else $error("over-current did not latch channel off");
endmodule
`default_nettype wire

// *** verif/smr_sat_model.sv ***
`default_nettype none
module smr_sat_model
(
   // clock
   input wire logic clk_i,
   // modulated supply current, 1 = high
   output var logic line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line_o = 1'h0;
   // data bits may run shorter than the sync pair, to provoke early edges
   int cut = 0;
   //////////////////////////////////////////////////////////////////
   // oldest bit sits at bits[n-1]; the first two bits last bt cycles, the rest bt - cut
   task automatic send(input logic [31:0] bits, input int n, input int bt);
      logic v;
      int t;
      for (int i = n - 1; i >= 0; i--)
      begin
         v = bits[i];
         t = (i >= n - 2) ? bt : bt - cut;
         line_o <= v;
         repeat (t / 2) @(posedge clk_i);
         line_o <= ~v;
         repeat (t - t / 2) @(posedge clk_i);
      end
      // back to idle low and hold well past the idle span
      line_o <= 1'h0;
      repeat (2 * bt) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// *** verif/tb_smr_top.sv ***
`default_nettype none
module tb_smr_top;
   timeunit 1ns;
   timeprecision 1ps;
   import smr_pkg::*;
   localparam int BT = 700;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic ce_i = 1'h1;
   smr_wb_req_t wb_i = '0;
   smr_wb_rsp_t wb_o;
   wire logic [3:0] cmp_i;
   logic [3:0] ilim_i = 4'h0;
   logic [3:0] sensor_supply_out_o;
   smr_cmp_t [3:0] cmp_cfg_o;
   logic message_waiting_out_o;
   int errors = 0;
   int checks = 0;
   int seed = 39904;
   logic [31:0] q;
   logic [11:0] d [0:4];
   logic [10:0] b [0:1];

   always #12.5 clk_i = ~clk_i;

   smr_top u_smr_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i), .wb_o(wb_o),
      .cmp_i(cmp_i), .ilim_i(ilim_i), .sensor_supply_out_o(sensor_supply_out_o),
      .cmp_cfg_o(cmp_cfg_o), .message_waiting_out_o(message_waiting_out_o));

   for (genvar g = 0; g < NCH; g++)
   begin : g_sat
      smr_sat_model u_smr_sat_model (.clk_i(clk_i), .line_o(cmp_i[g]));
   end
   //////////////////////////////////////////////////////////////////
   function automatic logic [4:0] crc5(input logic [11:0] v);
      logic [4:0] c;
      c = 5'h00;
      for (int i = 11; i >= 0; i--)
         c = {c[3:0], 1'h0} ^ ((c[4] ^ v[i]) ? CRC_POLY : 5'h00);
      return c;
   endfunction

   function automatic logic [31:0] frame_a(input logic [11:0] v, input logic [4:0] flip);
      return {13'h0000, 2'h0, v, crc5(v) ^ flip};
   endfunction

   // odd parity is selected, so data and parity together xor to one
   function automatic logic [31:0] frame_b(input logic [10:0] v, input logic flip);
      return {18'h00000, 2'h0, v, ~^v ^ flip};
   endfunction

   function automatic logic [31:0] ent(input logic l, input logic [1:0] n,
      input logic [1:0] c, input logic [11:0] v);
      return {15'h0000, l, n, c, v};
   endfunction
   //////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // entered just after a rising edge; holds the request until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      wb_i <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: a, sel: 4'hF, dat: v};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_o.ack !== 1'h1 && n < 40);
      chk("bus ack", {31'h0, wb_o.ack}, 32'h1);
      q = wb_o.dat;
      wb_i <= '0;
      @(posedge clk_i);
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      wb(1'h0, a, 32'h0);
      chk(what, q, exp);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (90000) @(posedge clk_i);
      errors++;
      close_out();
   end

   initial
   begin
      for (int i = 1; i < 5; i++)
         d[i] = 12'($random(seed));
      d[0] = 12'hFFF;
      b[0] = 11'h000;
      b[1] = 11'($random(seed));
      repeat (20) @(posedge clk_i);
      chk("reset outs", {27'h0, sensor_supply_out_o, message_waiting_out_o}, 32'h0);
      rst_i <= 1'h0;
      @(posedge clk_i);
      rd("mcr reset", A_MCR, 32'h0);
      rd("stat reset", A_STAT, 32'h0);
      wb(1'h1, 8'h30, 32'hFFFF);
      rd("unmapped", 8'h30, 32'h0);
      wb(1'h1, A_MCR, 32'h1800);
      wb(1'h1, A_CCR, 32'h1A1);
      wb(1'h1, A_CCR + 8'h04, 32'h21);
      wb(1'h1, A_CCR + 8'h08, 32'h21);
      wb(1'h1, A_CCR + 8'h0C, 32'h39);
      rd("mcr", A_MCR, 32'h1800);
      rd("ccr4", A_CCR + 8'h0C, 32'h39);
      chk("cmp cfg", {29'h0, cmp_cfg_o[0]}, 32'h5);
      chk("supply on", {28'h0, sensor_supply_out_o}, 32'hF);
      repeat (PWRUP_CYC) @(posedge clk_i);
      // crc flipped on ch2, one bit too many on ch3
      fork
         g_sat[0].u_smr_sat_model.send(frame_a(d[0], 5'h00), 19, BT);
         g_sat[1].u_smr_sat_model.send(frame_a(d[1], 5'h01), 19, BT);
         g_sat[2].u_smr_sat_model.send(frame_a(d[2], 5'h00) << 1, 20, BT);
         g_sat[3].u_smr_sat_model.send(frame_b(b[0], 1'h0), 14, BT);
      join
      repeat (20) @(posedge clk_i);
      chk("msg set", {31'h0, message_waiting_out_o}, 32'h1);
      // ch2 sync too slow for the range, ch4 parity flipped
      fork
         g_sat[0].u_smr_sat_model.send(frame_a(d[3], 5'h00), 19, BT);
         g_sat[1].u_smr_sat_model.send(frame_a(d[1], 5'h00), 19, 900);
         g_sat[3].u_smr_sat_model.send(frame_b(b[1], 1'h1), 14, BT);
      join
      wb(1'h1, A_CCR + 8'h08, 32'h20);
      fork
         g_sat[0].u_smr_sat_model.send(frame_a(d[4], 5'h00), 19, BT);
         g_sat[2].u_smr_sat_model.send(frame_a(d[2], 5'h00), 19, BT);
      join
      repeat (20) @(posedge clk_i);
      rd("stat full", A_STAT, 32'h9A10);
      rd("fifo1 a", A_FIFO, ent(1'h1, 2'h2, E_NONE, d[3]));
      wb(1'h1, A_FLUSH, 32'h1);
      rd("fifo1 b", A_FIFO, 32'h0);
      rd("fifo2 a", A_FIFO + 8'h04, ent(1'h0, 2'h2, E_CHK, d[1]));
      rd("fifo2 b", A_FIFO + 8'h04, ent(1'h0, 2'h1, E_BIT, 12'h000));
      rd("fifo3", A_FIFO + 8'h08, ent(1'h0, 2'h1, E_MANY, 12'h000));
      rd("fifo4 a", A_FIFO + 8'h0C, ent(1'h0, 2'h2, E_NONE, {1'h0, b[0]}));
      rd("fifo4 b", A_FIFO + 8'h0C, ent(1'h0, 2'h1, E_CHK, {1'h0, b[1]}));
      rd("stat empty", A_STAT, 32'h0);
      repeat (3) @(posedge clk_i);
      chk("msg clear", {31'h0, message_waiting_out_o}, 32'h0);
      wb(1'h1, A_MCR, 32'h1801);
      repeat (3) @(posedge clk_i);
      chk("msg low act", {31'h0, message_waiting_out_o}, 32'h1);
      // hold ch2 in current limit across the fault timer
      ilim_i <= 4'h2;
      repeat (FAULT_CYC - 12'h00A) @(posedge clk_i);
      chk("oc early", {28'h0, sensor_supply_out_o}, 32'hF);
      // clock enable low must freeze the fault timer
      ce_i <= 1'h0;
      repeat (100) @(posedge clk_i);
      chk("ce freeze", {28'h0, sensor_supply_out_o}, 32'hF);
      ce_i <= 1'h1;
      repeat (40) @(posedge clk_i);
      chk("oc latch", {28'h0, sensor_supply_out_o}, 32'hD);
      ilim_i <= 4'h0;
      rd("stat oc", A_STAT, 32'h2);
      wb(1'h1, A_CCR + 8'h04, 32'h21);
      repeat (3) @(posedge clk_i);
      chk("oc rearm", {28'h0, sensor_supply_out_o}, 32'hF);
      // sync pair alone leaves no centre; then squeezed data gives two early edges
      g_sat[0].u_smr_sat_model.send(32'h0, 2, BT);
      g_sat[0].u_smr_sat_model.cut = 400;
      g_sat[0].u_smr_sat_model.send(frame_a(12'h000, 5'h00), 19, BT);
      wb(1'h1, A_MCR, 32'h1803);
      chk("msg select", {31'h0, message_waiting_out_o}, 32'h1);
      repeat (3) @(posedge clk_i);
      chk("msg active low", {31'h0, message_waiting_out_o}, 32'h0);
      rd("fifo1 gap", A_FIFO, ent(1'h0, 2'h2, E_BIT, 12'h000));
      rd("fifo1 early", A_FIFO, ent(1'h0, 2'h1, E_BIT, 12'h000));
      close_out();
   end
endmodule
`default_nettype wire
